//--- rtl/touch_key_command_responder.sv
/*
 Command responder: takes one command byte at a time from the serial
 host port, answers with a fixed-length reply through a two-entry
 buffer, and drives reset/scan-halt strobes toward the device core.
 Assumes the serial framing, key data and setups memory sit in the same
 clock domain and present their values as flat ports.
*/
`timescale 1ns/1ns
`default_nettype none

// How it works
// - reset code twice within 100 ms
// - reset acknowledged with complement before reset
// - lone reset code times out silently
// - status returns byte plus CRC-8
// - status bit 6 marks unknown command
// - first-key bit 7 marks multiple touches
// - first-key bit 6 marks any fault
// - low six bits key index or 63
// - CRC-8 over command and data
// - all keys: six bytes plus CRC
// - signals: 96 bytes low first
// - references: 96 bytes low first
// - deltas: reference minus signal bytes
// - error flags: six bytes plus CRC
// - failure mode: byte plus CRC
// - dump halts scanning, CRC-16, restarts
// - dump words low byte first
// - dump aborts after 100 ms stall
// - last-command clears comms error
module touch_key_command_responder #(
	parameter int WINDOW_COUNT = touch_cmd_pkg::WINDOW_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_valid,
	output logic cmd_ready,
	output logic [7:0] rsp_data,
	output logic rsp_valid,
	input wire logic rsp_ready,
	input wire logic [touch_cmd_pkg::NUM_KEYS-1:0] key_detect,
	input wire logic [touch_cmd_pkg::NUM_KEYS-1:0] key_error,
	input wire logic [touch_cmd_pkg::NUM_KEYS*16-1:0] key_signal,
	input wire logic [touch_cmd_pkg::NUM_KEYS*16-1:0] key_reference,
	input wire logic [7:0] fail_mode_bits,
	input wire logic fault_any,
	input wire logic [7:0] setup_byte,
	output logic [7:0] setup_index,
	output logic scan_halt,
	output logic reset_request
);
	import touch_cmd_pkg::*;

	// ------------------------------------------------------------
	// Types and state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_RESET = 3'b100
	} state_e;

	state_e state; // Main sequencer
	logic [7:0] cmd; // Command being answered
	logic [7:0] last_cmd; // Last command byte seen
	logic [8:0] idx; // Reply byte index
	logic [8:0] len; // Reply length
	logic [7:0] crc8; // Running CRC-8
	logic [15:0] crc16; // Running CRC-16 for the dump
	logic comms_err; // Unknown command flag
	logic reset_armed; // First reset copy seen
	logic [31:0] timer; // Reset window / dump stall timer
	logic [7:0] out_byte; // Current reply byte
	logic in_ready; // Buffer can take a byte
	logic push; // Byte pushed into buffer
	logic take; // Command byte accepted

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// One byte of CRC-8, MSB first
	function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ CRC8_POLY) : (r << 1);
		end
		return r;
	endfunction

	// One byte of CRC-16, MSB first
	function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ((r << 1) ^ CRC16_POLY) : (r << 1);
		end
		return r;
	endfunction

	// Byte n of a flat key bitfield
	function automatic logic [7:0] field_byte(input logic [NUM_KEYS-1:0] f, input logic [8:0] n);
		return f[n[2:0]*8 +: 8];
	endfunction

	// Sixteen-bit word of key k from a flat vector
	function automatic logic [15:0] key_word(input logic [NUM_KEYS*16-1:0] v, input logic [5:0] k);
		return v[k*16 +: 16];
	endfunction

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic [5:0] first_key;
	logic multi;
	logic [7:0] key_report;
	logic [15:0] sig_w;
	logic [15:0] ref_w;
	logic [5:0] key_n;

	// Lowest touched key and multiple-touch flag
	always_comb begin
		first_key = NO_KEY;
		multi = 1'b0;
		for (int k = NUM_KEYS - 1; k >= 0; k--) begin
			if (key_detect[k]) begin
				first_key = 6'(k);
			end
		end
		if ((key_detect & (key_detect - 1'b1)) != '0) begin
			multi = 1'b1;
		end
	end

	// Any fault, comms error included, raises bit 6
	assign key_report = {multi, fault_any | comms_err, first_key};

	assign key_n = idx[8] ? 6'h00 : 6'(idx[7:1]);
	assign sig_w = key_word(key_signal, key_n);
	assign ref_w = key_word(key_reference, key_n);

	// Reply byte for the current index
	always_comb begin
		out_byte = 8'h00;
		case (cmd)
			CMD_RESET: out_byte = ~CMD_RESET;
			CMD_STATUS: begin
				out_byte = (idx == 9'h000) ? {1'b0, comms_err, 6'h00} : crc8;
			end
			CMD_FIRST_KEY: out_byte = (idx == 9'h000) ? key_report : crc8;
			CMD_ALL_KEYS: begin
				out_byte = (idx < 9'(FIELD_BYTES)) ? field_byte(key_detect, idx) : crc8;
			end
			CMD_ERRORS: begin
				out_byte = (idx < 9'(FIELD_BYTES)) ? field_byte(key_error, idx) : crc8;
			end
			CMD_FAIL_MODE: out_byte = (idx == 9'h000) ? fail_mode_bits : crc8;
			CMD_SIGNALS: out_byte = idx[0] ? sig_w[15:8] : sig_w[7:0];
			CMD_REFS: out_byte = idx[0] ? ref_w[15:8] : ref_w[7:0];
			CMD_DELTAS: begin
				out_byte = 8'(key_word(key_reference, 6'(idx)) - key_word(key_signal, 6'(idx)));
			end
			CMD_DUMP: begin
				// Setup area as stored, then CRC low byte first
				if (idx < 9'(SETUP_BYTES)) begin
					out_byte = setup_byte;
				end else if (idx == 9'(SETUP_BYTES)) begin
					out_byte = crc16[7:0];
				end else begin
					out_byte = crc16[15:8];
				end
			end
			CMD_LAST: out_byte = ~last_cmd; // Command before this one, complemented
			default: out_byte = 8'h00;
		endcase
	end

	assign setup_index = idx[7:0];
	assign push = (state == ST_SEND) && in_ready;
	// Commands are only taken while no reply is running
	assign cmd_ready = (state == ST_IDLE);
	assign take = cmd_valid && cmd_ready;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Starts replies, counts bytes, handles the reset pair
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			cmd <= 8'h00;
			idx <= 9'h000;
			len <= 9'h000;
			reset_armed <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (take) begin
						cmd <= cmd_data;
						idx <= 9'h000;
						reset_armed <= 1'b0; // Any other command breaks the pair
						state <= ST_SEND;
						case (cmd_data)
							CMD_RESET: begin
								if (reset_armed) begin
									len <= 9'd1;
								end else begin
									reset_armed <= 1'b1;
									state <= ST_IDLE;
								end
							end
							CMD_STATUS, CMD_FIRST_KEY, CMD_FAIL_MODE: len <= 9'd2;
							CMD_ALL_KEYS, CMD_ERRORS: len <= 9'(FIELD_BYTES + 1);
							CMD_SIGNALS, CMD_REFS: len <= 9'(NUM_KEYS * 2);
							CMD_DELTAS: len <= 9'(NUM_KEYS);
							CMD_DUMP: len <= 9'(SETUP_BYTES + 2);
							CMD_LAST: len <= 9'd1;
							default: state <= ST_IDLE; // Null and unknown: no reply
						endcase
					end else if (reset_armed && timer == 32'd0) begin
						reset_armed <= 1'b0; // Silent timeout
					end
				end
				ST_SEND: begin
					if (cmd == CMD_DUMP && timer == 32'd0) begin
						state <= ST_IDLE; // Stalled host
					end else if (push) begin
						idx <= idx + 9'd1;
						if (idx + 9'd1 == len) begin
							state <= (cmd == CMD_RESET) ? ST_RESET : ST_IDLE;
						end
					end
				end
				ST_RESET: begin
					// Hold until the acknowledge has left the buffer
					if (!rsp_valid) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Window and stall timer: reloads on each accepted or taken byte
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			timer <= 32'd0;
		end else if (take || (rsp_valid && rsp_ready)) begin
			timer <= 32'(WINDOW_COUNT - 1);
		end else if (timer != 32'd0) begin
			timer <= timer - 32'd1;
		end
	end

	// Running CRC-8 seeded with the command byte; CRC-16 starts from zero
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			crc8 <= 8'h00;
			crc16 <= 16'h0000;
		end else if (take) begin
			crc8 <= crc8_step(8'h00, cmd_data);
			crc16 <= 16'h0000;
		end else if (push) begin
			crc8 <= crc8_step(crc8, out_byte);
			// CRC-16 covers the setup bytes only, not its own bytes
			crc16 <= (idx < 9'(SETUP_BYTES)) ? crc16_step(crc16, out_byte) : crc16;
		end
	end

	// Comms error: unknown sets, last-command clears, set wins
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			comms_err <= 1'b0;
			last_cmd <= 8'h00;
		end else if (take) begin
			last_cmd <= (cmd_data == CMD_LAST) ? last_cmd : cmd_data; // Keep the one before
			case (cmd_data)
				CMD_NULL, CMD_RESET, CMD_STATUS, CMD_FIRST_KEY, CMD_ALL_KEYS,
				CMD_SIGNALS, CMD_REFS, CMD_DELTAS, CMD_ERRORS, CMD_FAIL_MODE,
				CMD_DUMP: begin
				end
				CMD_LAST: comms_err <= 1'b0;
				default: comms_err <= 1'b1;
			endcase
		end
	end

	// Core strobes: scan halted from one cycle after the dump send starts until one cycle after it ends, reset after the ack
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			scan_halt <= 1'b0;
			reset_request <= 1'b0;
		end else begin
			scan_halt <= (state == ST_SEND) && (cmd == CMD_DUMP);
			reset_request <= (state == ST_RESET) && !rsp_valid;
		end
	end

	// ------------------------------------------------------------
	// Two-entry reply buffer
	// ------------------------------------------------------------
	// A stalled host only fills it; the sequencer waits on in_ready
	logic [7:0] buf_mem [2];
	logic buf_wr;
	logic buf_rd;
	logic [1:0] buf_cnt;

	assign in_ready = (buf_cnt != 2'd2);
	assign rsp_valid = (buf_cnt != 2'd0);
	assign rsp_data = buf_mem[buf_rd];

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			buf_wr <= 1'b0;
			buf_rd <= 1'b0;
			buf_cnt <= 2'd0;
			buf_mem[0] <= 8'h00;
			buf_mem[1] <= 8'h00;
		end else begin
			if (push) begin
				buf_mem[buf_wr] <= out_byte;
				buf_wr <= ~buf_wr;
			end
			if (rsp_valid && rsp_ready) begin
				buf_rd <= ~buf_rd;
			end
			buf_cnt <= buf_cnt + 2'(push) - 2'(rsp_valid && rsp_ready);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence reset_pair_s;
		take && cmd_data == CMD_RESET && reset_armed;
	endsequence

	reset_ack_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		reset_pair_s |-> ##2 rsp_valid && rsp_data == 8'hFB)
		else $error("reset ack not sent");
	lone_reset_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		take && cmd_data == CMD_RESET && !reset_armed |=> state == ST_IDLE && reset_armed)
		else $error("first reset copy answered");
	no_overlap_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		state != ST_IDLE |=> $stable(cmd))
		else $error("command taken during reply");
	unknown_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		take && cmd_data > CMD_LAST |=> comms_err)
		else $error("unknown command not flagged");
	last_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		take && cmd_data == CMD_LAST |=> !comms_err)
		else $error("comms error not cleared");
	halt_dump_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		state == ST_SEND && cmd == CMD_DUMP |=> scan_halt)
		else $error("scan not halted");
	no_key_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		key_detect == '0 |-> key_report[5:0] == 6'h3F && !key_report[7])
		else $error("no-key code wrong");
	status_len_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		take && cmd_data == CMD_STATUS |=> len == 9'd2)
		else $error("status length wrong");
endmodule

`default_nettype wire

//--- rtl/touch_cmd_pkg.sv
/*
 Package for the touch-key command responder: command codes, reply
 lengths, status bit positions and timing counts.
 Assumes a 25 MHz device clock.
*/
package touch_cmd_pkg;
	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_NULL = 8'h00;
	localparam logic [7:0] CMD_RESET = 8'h04;
	localparam logic [7:0] CMD_STATUS = 8'h05;
	localparam logic [7:0] CMD_FIRST_KEY = 8'h06;
	localparam logic [7:0] CMD_ALL_KEYS = 8'h07;
	localparam logic [7:0] CMD_SIGNALS = 8'h08;
	localparam logic [7:0] CMD_REFS = 8'h09;
	localparam logic [7:0] CMD_DELTAS = 8'h0A;
	localparam logic [7:0] CMD_ERRORS = 8'h0B;
	localparam logic [7:0] CMD_FAIL_MODE = 8'h0C;
	localparam logic [7:0] CMD_DUMP = 8'h0D;
	localparam logic [7:0] CMD_LAST = 8'h0F;
	// ------------------------------------------------------------
	// Sizes and fields
	// ------------------------------------------------------------
	localparam int NUM_KEYS = 48;
	localparam int FIELD_BYTES = 6;
	localparam int SETUP_BYTES = 247;
	localparam logic [5:0] NO_KEY = 6'h3F;
	localparam int STAT_COMMS_BIT = 6;
	localparam int KEY_MULTI_BIT = 7;
	localparam int KEY_FAULT_BIT = 6;
	localparam logic [7:0] CRC8_POLY = 8'h31;
	localparam logic [15:0] CRC16_POLY = 16'h1021;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int WINDOW_MS = 100;
	localparam int WINDOW_CYCLES = CLK_HZ / 1000 * WINDOW_MS;
endpackage

//--- bench/host_sink.sv
/*
 Host-side model of the reply port: takes reply bytes into a queue.
 Assumes the bench clears the queue and drives slow and hold.
*/
`timescale 1ns/1ns
`default_nettype none
module host_sink (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_valid,
	output logic rsp_ready,
	input wire logic slow,
	input wire logic hold
);
	// Bytes taken so far, read and cleared by the bench
	logic [7:0] got[$];
	// ----------------------------------------
	// Ready: prompt, random stalls, or a full stop
	// ----------------------------------------
	// A full stop breaks the per-byte time limit on purpose
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rsp_ready <= 1'b0;
		end else begin
			rsp_ready <= !hold && (!slow || ($urandom % 3 == 0));
		end
	end
	// One handshake pulls exactly one reply byte
	always @(posedge ref_clk) begin
		if (rstn && rsp_valid === 1'b1 && rsp_ready) begin
			got.push_back(rsp_data);
		end
	end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
/*
 Self-checking bench for the command responder.
 Assumes a short window count so the timeouts fit a short run.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import touch_cmd_pkg::*;
	localparam int WIN = 50;
	// Commands swept with fresh random key data
	localparam logic [7:0] CMD_SET [7] = '{CMD_FIRST_KEY, CMD_ALL_KEYS, CMD_ERRORS,
		CMD_FAIL_MODE, CMD_SIGNALS, CMD_REFS, CMD_DELTAS};
	logic ref_clk, rstn, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
	logic scan_halt, reset_request, fault_any, slow, hold;
	logic [7:0] cmd_data, rsp_data, fail_mode_bits, setup_index, setup_byte;
	logic [NUM_KEYS-1:0] key_detect, key_error;
	logic [NUM_KEYS*16-1:0] key_signal, key_reference;
	logic [7:0] exp[$];
	int mismatches, checked, resets, at_reset, halt_cyc;
	// Setup area content is a fixed pattern of the index
	function automatic logic [7:0] sbyte(input logic [7:0] i);
		return (i * 8'h1D) ^ 8'hA5;
	endfunction
	assign setup_byte = sbyte(setup_index);
	touch_key_command_responder #(.WINDOW_COUNT(WIN)) touch_key_command_responder_i (
		.ref_clk(ref_clk), .rstn(rstn), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
		.rsp_ready(rsp_ready), .key_detect(key_detect), .key_error(key_error),
		.key_signal(key_signal), .key_reference(key_reference),
		.fail_mode_bits(fail_mode_bits), .fault_any(fault_any), .setup_byte(setup_byte),
		.setup_index(setup_index), .scan_halt(scan_halt), .reset_request(reset_request));
	host_sink host_sink_i (.ref_clk(ref_clk), .rstn(rstn), .rsp_data(rsp_data),
		.rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .slow(slow), .hold(hold));
	// ----------------------------------------
	// Clock, monitors, watchdog
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (reset_request === 1'b1) begin
			resets++;
			at_reset = host_sink_i.got.size();
		end
		if (scan_halt === 1'b1) halt_cyc++;
	end
	initial begin
		#(40 * 100000);
		mismatches++;
		print_verdict();
	end
	// ----------------------------------------
	// Checks and expectations
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [7:0] crc8q(input logic [7:0] c, input logic [7:0] q[$]);
		logic [7:0] r;
		r = 8'h00;
		for (int i = -1; i < q.size(); i++) begin
			r ^= (i < 0) ? c : q[i];
			repeat (8) r = r[7] ? ({r[6:0], 1'b0} ^ CRC8_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction
	// Lowest touched index wins; more than one touch sets the top bit
	function automatic logic [7:0] first_key(input logic [47:0] d, input logic f);
		logic [5:0] idx;
		int cnt;
		idx = NO_KEY;
		cnt = 0;
		for (int k = NUM_KEYS - 1; k >= 0; k--) begin
			if (d[k]) begin
				idx = 6'(k);
				cnt++;
			end
		end
		return {cnt > 1, f, idx};
	endfunction
	function automatic void build(input logic [7:0] c);
		logic [15:0] w, cr;
		exp.delete();
		cr = 16'h0000;
		for (int k = 0; k < NUM_KEYS; k++) begin
			w = (c == CMD_SIGNALS) ? key_signal[16*k+:16] : key_reference[16*k+:16];
			if (c == CMD_DELTAS) exp.push_back(8'(w - key_signal[16*k+:16]));
			if (c == CMD_SIGNALS || c == CMD_REFS) exp.push_back(w[7:0]);
			if (c == CMD_SIGNALS || c == CMD_REFS) exp.push_back(w[15:8]);
		end
		for (int i = 0; i < FIELD_BYTES; i++) begin
			if (c == CMD_ALL_KEYS) exp.push_back(key_detect[8*i+:8]);
			if (c == CMD_ERRORS) exp.push_back(key_error[8*i+:8]);
		end
		if (c == CMD_FIRST_KEY) exp.push_back(first_key(key_detect, fault_any));
		if (c == CMD_FAIL_MODE) exp.push_back(fail_mode_bits);
		if (c inside {CMD_FIRST_KEY, CMD_ALL_KEYS, CMD_ERRORS, CMD_FAIL_MODE})
			exp.push_back(crc8q(c, exp));
		if (c == CMD_DUMP) begin
			for (int i = 0; i < SETUP_BYTES; i++) begin
				exp.push_back(sbyte(8'(i)));
				cr ^= {sbyte(8'(i)), 8'h00};
				repeat (8) cr = cr[15] ? ((cr << 1) ^ CRC16_POLY) : (cr << 1);
			end
			exp.push_back(cr[7:0]);
			exp.push_back(cr[15:8]);
		end
	endfunction
	// ----------------------------------------
	// Drivers, all at the falling edge
	// ----------------------------------------
	task automatic send(input logic [7:0] c);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		chk("command ready", 16'h0001, 16'(cmd_ready));
		cmd_data = c;
		cmd_valid = 1'b1;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
	endtask
	// Send, wait for n bytes, then make sure nothing more follows
	task automatic run(input logic [7:0] c, input int n);
		int t;
		host_sink_i.got.delete();
		send(c);
		t = 0;
		while (host_sink_i.got.size() < n && t < 5000) begin
			@(negedge ref_clk);
			t++;
		end
		repeat (20) @(negedge ref_clk);
		chk("reply length", 16'(n), 16'(host_sink_i.got.size()));
	endtask
	task automatic cmpq(input logic [7:0] c);
		build(c);
		run(c, exp.size());
		foreach (exp[i]) chk("reply byte", 16'(exp[i]), 16'(host_sink_i.got[i]));
		$display("test done: command %h", c);
	endtask
	task automatic rnd();
		for (int i = 0; i < NUM_KEYS / 2; i++) begin
			key_signal[32*i+:32] = $urandom;
			key_reference[32*i+:32] = $urandom;
		end
		key_detect = 48'({$urandom, $urandom});
		key_error = 48'({$urandom, $urandom});
		fail_mode_bits = 8'($urandom);
		fault_any = 1'($urandom);
		slow = 1'($urandom);
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rstn = 1'b0;
		cmd_valid = 1'b0;
		cmd_data = 8'h00;
		hold = 1'b0;
		void'($urandom(32'h35900B43));
		rnd();
		fault_any = 1'b0;
		key_detect = '0;
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		rstn = 1'b1;
		@(negedge ref_clk);
		run(CMD_STATUS, 2);
		chk("status comms bit", 16'h0000, 16'(host_sink_i.got[0][STAT_COMMS_BIT]));
		chk("status reserved", 16'h0000, 16'(host_sink_i.got[0][7]));
		chk("status crc", 16'(crc8q(CMD_STATUS, {host_sink_i.got[0]})), 16'(host_sink_i.got[1]));
		run(8'h20, 0);
		run(CMD_STATUS, 2);
		chk("status comms bit", 16'h0001, 16'(host_sink_i.got[0][STAT_COMMS_BIT]));
		chk("key comms bit", 16'h007F, 16'(first_key(key_detect, 1'b1)));
		exp = {8'h7F};
		exp.push_back(crc8q(CMD_FIRST_KEY, exp));
		run(CMD_FIRST_KEY, 2);
		foreach (exp[i]) chk("first key", 16'(exp[i]), 16'(host_sink_i.got[i]));
		run(CMD_LAST, 1);
		chk("last command", 16'h00F9, 16'(host_sink_i.got[0]));
		run(CMD_STATUS, 2);
		chk("status cleared", 16'h0000, 16'(host_sink_i.got[0][STAT_COMMS_BIT]));
		for (int j = 0; j < 4; j++) begin
			rnd();
			if (j == 0) key_detect = 48'h800000000000;
			if (j == 1) key_detect = '0;
			foreach (CMD_SET[m]) cmpq(CMD_SET[m]);
		end
		slow = 1'b1;
		halt_cyc = 0;
		cmpq(CMD_DUMP);
		chk("halt during dump", 16'h0001, 16'(halt_cyc > SETUP_BYTES));
		chk("halt released", 16'h0000, 16'(scan_halt));
		hold = 1'b1;
		host_sink_i.got.delete();
		send(CMD_DUMP);
		repeat (4 * WIN) @(negedge ref_clk);
		chk("halt after stall", 16'h0000, 16'(scan_halt));
		chk("ready after stall", 16'h0001, 16'(cmd_ready));
		hold = 1'b0;
		repeat (20) @(negedge ref_clk);
		chk("aborted dump short", 16'h0001, 16'(host_sink_i.got.size() < SETUP_BYTES));
		$display("test done: dump timeout");
		// Host side gives up on the cut reply and asks again
		cmpq(CMD_DUMP);
		resets = 0;
		run(CMD_RESET, 0);
		repeat (WIN + 20) @(negedge ref_clk);
		run(CMD_RESET, 0);
		repeat (WIN + 20) @(negedge ref_clk);
		run(CMD_RESET, 0);
		run(CMD_STATUS, 2);
		run(CMD_RESET, 0);
		repeat (WIN + 20) @(negedge ref_clk);
		chk("no reset yet", 16'h0000, 16'(resets));
		run(CMD_RESET, 0);
		run(CMD_RESET, 1);
		chk("reset ack", 16'h00FB, 16'(host_sink_i.got[0]));
		chk("reset pulses", 16'h0001, 16'(resets));
		chk("ack before reset", 16'h0001, 16'(at_reset));
		$display("test done: forced reset");
		print_verdict();
	end
endmodule
`default_nettype wire
